// ---- rtl/vpr_pkg.sv ----
`default_nettype none
package vpr_pkg;
   // ==========================================================
   // Register select codes on the two address inputs
   localparam logic [1:0] SEL_MODE   = 2'h0;
   localparam logic [1:0] SEL_XCOORD = 2'h1;
   localparam logic [1:0] SEL_YCOORD = 2'h2;
   localparam logic [1:0] SEL_DATA   = 2'h3;
   localparam logic [1:0] SEL_TTX    = 2'h2;
   // ==========================================================
   // Operating mode codes
   localparam logic [2:0] MODE_PIXEL   = 3'h0;
   localparam logic [2:0] MODE_LUTADDR = 3'h1;
   localparam logic [2:0] MODE_LUTDATA = 3'h2;
   localparam logic [2:0] MODE_SWITCH  = 3'h3;
   localparam logic [2:0] MODE_SCROLL  = 3'h4;
   localparam logic [2:0] MODE_TTX     = 3'h5;
   localparam logic [2:0] MODE_PAGE    = 3'h6;
   // ==========================================================
   // Field positions
   localparam int MODE_SUB_BIT   = 3;
   localparam int LA_TRANSPARENCY_BIT_BIT    = 7;
   localparam int LA_RED_BIT     = 6;
   localparam int LA_GREEN_BIT   = 5;
   localparam int LA_BLUE_BIT    = 4;
   localparam int TRANSPARENCY_BIT_DATA_BIT  = 3;
   localparam int SW_LINE_BIT    = 7;
   localparam int SW_ILACE_BIT   = 6;
   localparam int SW_SYNC_BIT    = 5;
   localparam int SW_LSRC_BIT    = 4;
   localparam int SW_TEST_BIT    = 3;
   // ==========================================================
   // Reset values and steps
   localparam logic [3:0] MODE_RESET   = 4'h0;
   localparam logic [4:0] SWITCH_RESET = 5'h1f;
   localparam logic [2:0] PAGE_RESET   = 3'h0;
   localparam logic [7:0] LUTADDR_RESET = 8'h00;
   localparam logic [7:0] X_STEP       = 8'h02;
   localparam logic [7:0] SCROLL_MAX   = 8'hd1;
   localparam int         TTX_LOW_W    = 5;
   // ==========================================================
   // Timing
   localparam int CLK_HZ      = 50000000;
   localparam int TEST_HZ     = 1413000;
   localparam int TEST_DIV    = CLK_HZ / TEST_HZ;
endpackage
`default_nettype wire

// ---- rtl/vpr_regs.sv ----
// What this block does
// RL1 - Nibble mode: column lsb one uses high nibble and high bank strobe.
// RL2 - Nibble pixel accesses leave both drawing coordinates unchanged.
// RL3 - Byte mode writes store all eight bits, then X advances by two.
// RL4 - X wraps to zero and stays readable; Y never advances itself.
// RL5 - Byte mode ignores column lsb; high nibble odd, low nibble even.
// RL6 - Lookup-address mode: address 3 write loads enables and entry index.
// RL7 - Border, and graphics when source switch 0, use lookup address index.
// RL8 - Software restores border index before display after table reloads.
// RL9 - Lookup-data write stores into every enabled section at chosen entry.
// RL10 - Lookup-data read with several enables returns undefined data.
// RL11 - Transparency section keeps data bit 3 only; output follows it.
// RL12 - Lookup reads bypass the holding register; transparency unreadable.
// RL13 - Colour entries hold 4-bit level codes; upper data bits ignored.
// RL14 - Switch mode: address 3 write loads bits 7-3; all ones at reset.
// RL15 - Line sync select: one normal rate, zero early rate.
// RL16 - Interlace select: one gives 2:1, zero gives 1:1.
// RL17 - Sync source one: vertical sync input, composite sync disabled.
// RL18 - Lookup source: zero lookup address, one shift register pixel.
// RL19 - Test bit runs vertical machine and row counter at test rate.
// RL20 - Scroll mode: address 3 write loads offset 0 to 209; values above 209 are stored as written.
// RL21 - Teletext mode: address 2 loads pointer; low counter modulo 32.
// RL22 - Page bits keep their values during teletext transfers.
// RL23 - Page mode: address 3 loads 3-bit page code, readable in status.
// RL24 - Mode bit 3 picks submode, bits 2-0 pick mode; code 7 inert.
// RL25 - Pixel mode address 3 access makes DRAM access from coordinates.
// RL26 - Writes with no function in current mode change no register.
`timescale 1ns/10ps
`default_nettype none
module vpr_regs #(
   parameter int LUT_DEPTH = 16
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Processor pins
   input  wire logic        io_cs_n,
   input  wire logic        e_clk,
   input  wire logic        rd_wr,
   input  wire logic [1:0]  reg_sel,
   input  wire logic [7:0]  ad_in,
   output logic      [7:0]  ad_out_r,
   output logic             ad_oe_n_r,
   // Raster state
   input  wire logic        vblank_n,
   input  wire logic        hblank_n,
   input  wire logic        in_graphics,
   input  wire logic [3:0]  shift_pixel,
   // Pixel DRAM access
   output logic             pix_req_r,
   output logic             pix_we_r,
   output logic             pix_byte_r,
   output logic             high_bank_row_strobe_r,
   output logic             low_bank_row_strobe_r,
   output logic      [7:0]  pix_col_r,
   output logic      [7:0]  pix_row_r,
   output logic      [7:0]  pix_wdata_r,
   input  wire logic        pix_rd_valid,
   input  wire logic [7:0]  pix_rdata,
   // Teletext DMA
   input  wire logic        teletext_byte_done,
   input  wire logic        teletext_active,
   output logic      [12:0] teletext_addr_r,
   // Parameters to the raster logic
   output logic      [3:0]  mode_r,
   output logic      [2:0]  page_r,
   output logic      [7:0]  scroll_r,
   output logic             line_sync_rate_select_r,
   output logic             interlace_select_r,
   output logic             vsync_oe_n_r,
   output logic             csync_enable_r,
   output logic             lookup_source_select_r,
   output logic             factory_test_select_r,
   output logic             vsm_tick_test_r,
   // Colour generation
   output logic      [3:0]  red_level_r,
   output logic      [3:0]  green_level_r,
   output logic      [3:0]  blue_level_r,
   output logic             transparency_bit_r
);
   // ==========================================================
   // Reset release and pin synchronisers
   logic       rst_meta, rst_s_n;
   logic       cs_m, e_m, rw_m, cs_s, e_s, rw_s, e_d;
   logic [1:0] sel_m, sel_s;
   logic [7:0] ad_m, ad_s;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'b0;
         rst_s_n  <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_s_n  <= rst_meta;
      end
   end

   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         cs_m  <= 1'b1;
         cs_s  <= 1'b1;
         e_m   <= 1'b0;
         e_s   <= 1'b0;
         e_d   <= 1'b0;
         rw_m  <= 1'b1;
         rw_s  <= 1'b1;
         sel_m <= 2'h0;
         sel_s <= 2'h0;
         ad_m  <= 8'h00;
         ad_s  <= 8'h00;
      end else begin
         cs_m  <= io_cs_n;
         cs_s  <= cs_m;
         e_m   <= e_clk;
         e_s   <= e_m;
         e_d   <= e_s;
         rw_m  <= rd_wr;
         rw_s  <= rw_m;
         sel_m <= reg_sel;
         sel_s <= sel_m;
         ad_m  <= ad_in;
         ad_s  <= ad_m;
      end
   end

   // Write commits on the falling E edge, when the data is settled
   logic wr_stb, rd_stb;
   assign wr_stb = e_d && !e_s && !cs_s && !rw_s;
   assign rd_stb = !e_d && e_s && !cs_s && rw_s;

   function automatic logic hit(input logic [2:0] m, input logic [1:0] s,
                                input logic [2:0] cur_m,
                                input logic [1:0] cur_s);
      hit = (cur_m == m) && (cur_s == s);
   endfunction

   logic [2:0] mode_code;
   logic       byte_sub;
   assign mode_code = mode_r[2:0];
   assign byte_sub  = mode_r[vpr_pkg::MODE_SUB_BIT];

   logic pix_hit, lut_addr_wr, lookup_entry_data_hit, sw_wr, scroll_wr;
   logic ttx_hit, page_wr;
   assign pix_hit      = hit(vpr_pkg::MODE_PIXEL, vpr_pkg::SEL_DATA,
                             mode_code, sel_s); // RL25
   assign lut_addr_wr  = wr_stb && hit(vpr_pkg::MODE_LUTADDR,
                             vpr_pkg::SEL_DATA, mode_code, sel_s);
   assign lookup_entry_data_hit = hit(vpr_pkg::MODE_LUTDATA, vpr_pkg::SEL_DATA,
                             mode_code, sel_s);
   assign sw_wr        = wr_stb && hit(vpr_pkg::MODE_SWITCH,
                             vpr_pkg::SEL_DATA, mode_code, sel_s);
   assign scroll_wr    = wr_stb && hit(vpr_pkg::MODE_SCROLL,
                             vpr_pkg::SEL_DATA, mode_code, sel_s);
   assign ttx_hit      = hit(vpr_pkg::MODE_TTX, vpr_pkg::SEL_TTX,
                             mode_code, sel_s);
   assign page_wr      = wr_stb && hit(vpr_pkg::MODE_PAGE,
                             vpr_pkg::SEL_DATA, mode_code, sel_s);

   // ==========================================================
   // Mode register; code 7 is stored and reported but selects nothing
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n)
         mode_r <= vpr_pkg::MODE_RESET;
      else if (wr_stb && sel_s == vpr_pkg::SEL_MODE)
         mode_r <= ad_s[3:0]; // RL24
   end

   // ==========================================================
   // Drawing coordinates
   logic [7:0] x_r, y_r;
   logic       x_wr, y_wr, x_step;
   assign x_wr   = wr_stb && hit(vpr_pkg::MODE_PIXEL, vpr_pkg::SEL_XCOORD,
                                 mode_code, sel_s);
   assign y_wr   = wr_stb && hit(vpr_pkg::MODE_PIXEL, vpr_pkg::SEL_YCOORD,
                                 mode_code, sel_s);
   // Only byte writes advance X; Y is left to software
   assign x_step = wr_stb && pix_hit && byte_sub; // RL3

   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n)
         x_r <= 8'h00;
      else if (x_wr)
         x_r <= ad_s;
      else if (x_step)
         x_r <= x_r + vpr_pkg::X_STEP; // RL4
   end

   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n)
         y_r <= 8'h00;
      else if (y_wr)
         y_r <= ad_s; // RL4
   end

   // ==========================================================
   // Pixel access request towards the DRAM controller
   logic pix_go;
   assign pix_go = (wr_stb || rd_stb) && pix_hit;

   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         pix_req_r              <= 1'b0;
         pix_we_r               <= 1'b0;
         pix_byte_r             <= 1'b0;
         high_bank_row_strobe_r <= 1'b0;
         low_bank_row_strobe_r  <= 1'b0;
         pix_col_r              <= 8'h00;
         pix_row_r              <= 8'h00;
         pix_wdata_r            <= 8'h00;
      end else begin
         pix_req_r <= pix_go; // RL25
         if (pix_go) begin
            pix_we_r    <= wr_stb;
            pix_byte_r  <= byte_sub;
            pix_col_r   <= x_r;
            pix_row_r   <= y_r;
            pix_wdata_r <= ad_s; // RL3
            // Byte mode strobes both banks, so column lsb is ignored
            high_bank_row_strobe_r <= byte_sub || x_r[0]; // RL1 RL5
            low_bank_row_strobe_r  <= byte_sub || !x_r[0]; // RL1 RL5
         end
      end
   end

   // ==========================================================
   // Lookup address, switches, scroll, page
   logic [7:0] lut_addr_r;
   logic [4:0] sw_r;

   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n)
         lut_addr_r <= vpr_pkg::LUTADDR_RESET;
      else if (lut_addr_wr)
         lut_addr_r <= ad_s; // RL6
   end

   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n)
         sw_r <= vpr_pkg::SWITCH_RESET; // RL14
      else if (sw_wr)
         sw_r <= ad_s[vpr_pkg::SW_LINE_BIT:vpr_pkg::SW_TEST_BIT]; // RL14
   end

   // Values above 209 are stored as written; the raster logic must not
   // be handed one, so software keeps to the limit
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n)
         scroll_r <= 8'h00;
      else if (scroll_wr)
         scroll_r <= ad_s; // RL20
   end

   // Page changes only by an explicit write, never by DMA activity
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n)
         page_r <= vpr_pkg::PAGE_RESET;
      else if (page_wr)
         page_r <= ad_s[2:0]; // RL23 RL22
   end

   localparam int SWB = vpr_pkg::SW_TEST_BIT;
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         line_sync_rate_select_r <= 1'b1;
         interlace_select_r      <= 1'b1;
         vsync_oe_n_r            <= 1'b1;
         csync_enable_r          <= 1'b0;
         lookup_source_select_r  <= 1'b1;
         factory_test_select_r   <= 1'b1;
      end else begin
         line_sync_rate_select_r <= sw_r[vpr_pkg::SW_LINE_BIT - SWB]; // RL15
         interlace_select_r      <= sw_r[vpr_pkg::SW_ILACE_BIT - SWB]; // RL16
         // External sync: vertical sync pin turns input, composite off
         vsync_oe_n_r   <= sw_r[vpr_pkg::SW_SYNC_BIT - SWB]; // RL17
         csync_enable_r <= !sw_r[vpr_pkg::SW_SYNC_BIT - SWB]; // RL17
         lookup_source_select_r  <= sw_r[vpr_pkg::SW_LSRC_BIT - SWB]; // RL18
         factory_test_select_r   <= sw_r[0]; // RL19
      end
   end

   // Test-rate tick for the vertical machine and row counter
   logic [5:0] div_r;
   localparam logic [5:0] DIV_LAST = 6'(vpr_pkg::TEST_DIV - 1);
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         div_r           <= 6'h00;
         vsm_tick_test_r <= 1'b0;
      end else begin
         vsm_tick_test_r <= 1'b0;
         if (!sw_r[0] || div_r == DIV_LAST)
            div_r <= 6'h00;
         else
            div_r <= div_r + 6'h01;
         if (sw_r[0] && div_r == DIV_LAST)
            vsm_tick_test_r <= 1'b1; // RL19
      end
   end

   // ==========================================================
   // Colour lookup table
   logic [3:0] red_mem   [LUT_DEPTH];
   logic [3:0] green_mem [LUT_DEPTH];
   logic [3:0] blue_mem  [LUT_DEPTH];
   logic       transparency_bit_mem  [LUT_DEPTH];
   logic [3:0] lut_ent;
   logic       lut_wr;
   assign lut_ent = lut_addr_r[3:0];
   assign lut_wr  = wr_stb && lookup_entry_data_hit;

   // Every enabled section is written; upper data bits are dropped
   always_ff @(posedge mclk) begin
      if (lut_wr && lut_addr_r[vpr_pkg::LA_RED_BIT])
         red_mem[lut_ent] <= ad_s[3:0]; // RL9 RL13
      if (lut_wr && lut_addr_r[vpr_pkg::LA_GREEN_BIT])
         green_mem[lut_ent] <= ad_s[3:0]; // RL9 RL13
      if (lut_wr && lut_addr_r[vpr_pkg::LA_BLUE_BIT])
         blue_mem[lut_ent] <= ad_s[3:0]; // RL9 RL13
      if (lut_wr && lut_addr_r[vpr_pkg::LA_TRANSPARENCY_BIT_BIT])
         transparency_bit_mem[lut_ent] <= ad_s[vpr_pkg::TRANSPARENCY_BIT_DATA_BIT]; // RL9 RL11
   end

   // Colour index source: border always uses the lookup address
   logic [3:0] color_idx;
   assign color_idx = (in_graphics && lookup_source_select_r) ?
                      shift_pixel : lut_ent; // RL7 RL18

   always_ff @(posedge mclk) begin
      red_level_r        <= red_mem[color_idx];
      green_level_r      <= green_mem[color_idx];
      blue_level_r       <= blue_mem[color_idx];
      transparency_bit_r <= transparency_bit_mem[color_idx]; // RL11
   end

   // Several enables OR the sections together, which software must not
   // rely on; transparency has no read path
   logic [3:0] lut_rd;
   always_comb begin
      lut_rd = 4'h0;
      if (lut_addr_r[vpr_pkg::LA_RED_BIT])
         lut_rd = lut_rd | red_mem[lut_ent];
      if (lut_addr_r[vpr_pkg::LA_GREEN_BIT])
         lut_rd = lut_rd | green_mem[lut_ent];
      if (lut_addr_r[vpr_pkg::LA_BLUE_BIT])
         lut_rd = lut_rd | blue_mem[lut_ent]; // RL10 RL12
   end

   // ==========================================================
   // Teletext pointer and modulo-32 byte counter
   logic [7:0]                   ttx_hi_r;
   logic [vpr_pkg::TTX_LOW_W-1:0] ttx_lo_r;
   localparam logic [vpr_pkg::TTX_LOW_W-1:0] LO_LAST = '1;
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         ttx_hi_r <= 8'h00;
         ttx_lo_r <= '0;
      end else if (wr_stb && ttx_hit) begin
         ttx_hi_r <= ad_s; // RL21
         ttx_lo_r <= '0;
      end else if (teletext_byte_done) begin
         ttx_lo_r <= ttx_lo_r + 1'b1; // RL21
         if (ttx_lo_r == LO_LAST)
            ttx_hi_r <= ttx_hi_r + 8'h01; // RL21
      end else if (!hblank_n) begin
         ttx_lo_r <= '0;
      end
   end

   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n)
         teletext_addr_r <= 13'h0000;
      else
         teletext_addr_r <= {ttx_hi_r, ttx_lo_r};
   end

   // ==========================================================
   // Read path; driven while E is high and the chip is selected
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         ad_out_r  <= 8'h00;
         ad_oe_n_r <= 1'b1;
      end else begin
         ad_oe_n_r <= !(e_s && !cs_s && rw_s);
         if (rd_stb) begin
            case (sel_s)
               vpr_pkg::SEL_MODE:
                  ad_out_r <= {vblank_n, hblank_n, mode_code, page_r}; // RL23
               vpr_pkg::SEL_XCOORD:
                  ad_out_r <= (mode_code == vpr_pkg::MODE_PIXEL) ?
                              x_r : 8'h00; // RL4
               vpr_pkg::SEL_YCOORD:
                  ad_out_r <= (mode_code == vpr_pkg::MODE_PIXEL) ? y_r :
                              (mode_code == vpr_pkg::MODE_TTX) ?
                              ttx_hi_r : 8'h00; // RL21
               vpr_pkg::SEL_DATA:
                  ad_out_r <= lookup_entry_data_hit ? {4'h0, lut_rd} : 8'h00; // RL12
               default:
                  ad_out_r <= 8'h00;
            endcase
         end else if (pix_rd_valid) begin
            // Nibble read returns only the addressed nibble, in its lane
            if (pix_byte_r)
               ad_out_r <= pix_rdata;
            else if (high_bank_row_strobe_r)
               ad_out_r <= {pix_rdata[7:4], 4'h0}; // RL1
            else
               ad_out_r <= {4'h0, pix_rdata[3:0]}; // RL1
         end
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_s_n);

   sequence s_byte_write;
      wr_stb && pix_hit && byte_sub;
   endsequence

   a_byte_x_step: assert property (s_byte_write |=> // RL3
      x_r == $past(x_r) + vpr_pkg::X_STEP)
      else $error("byte write did not advance X by two");
   a_nibble_keeps_xy: assert property ( // RL2
      (pix_go && !byte_sub) |=> $stable(x_r) && $stable(y_r))
      else $error("nibble access changed a coordinate");
   a_byte_read_x: assert property ( // RL3
      (rd_stb && pix_hit) |=> $stable(x_r))
      else $error("pixel read changed X");
   a_bank_select: assert property ( // RL1
      (pix_go && !byte_sub) |=>
      pix_req_r && high_bank_row_strobe_r == $past(x_r[0]) &&
      low_bank_row_strobe_r == !$past(x_r[0]))
      else $error("wrong bank strobe in nibble mode");
   a_byte_banks: assert property ( // RL5
      (pix_go && byte_sub) |=>
      high_bank_row_strobe_r && low_bank_row_strobe_r)
      else $error("byte access must strobe both banks");
   a_lutaddr_load: assert property ( // RL6
      lut_addr_wr |=> lut_addr_r == $past(ad_s))
      else $error("lookup address not loaded");
   a_switch_out: assert property ( // RL17
      sw_wr |=> ##1 vsync_oe_n_r == $past(ad_s[vpr_pkg::SW_SYNC_BIT], 2) &&
      csync_enable_r != vsync_oe_n_r)
      else $error("sync source outputs wrong");
   a_page_stable: assert property ( // RL22
      (teletext_active && !page_wr) |=> $stable(page_r))
      else $error("page changed during teletext transfer");
   a_dead_write: assert property ( // RL26
      (wr_stb && mode_code == 3'h7 && sel_s != vpr_pkg::SEL_MODE) |=>
      $stable(x_r) && $stable(lut_addr_r) && $stable(sw_r) &&
      $stable(scroll_r) && $stable(page_r) && $stable(ttx_hi_r))
      else $error("inert write changed a register");
   a_ttx_carry: assert property ( // RL21
      (teletext_byte_done && !(wr_stb && ttx_hit) && ttx_lo_r == LO_LAST)
      |=> ttx_lo_r == '0 && ttx_hi_r == $past(ttx_hi_r) + 8'h01)
      else $error("teletext carry wrong");
endmodule
`default_nettype wire

// ---- test/vpr_dram_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module vpr_dram_model (
   // Clock
   input  wire logic       mclk,
   // Request side
   input  wire logic       pix_req,
   input  wire logic       pix_we,
   input  wire logic [7:0] pix_wdata,
   // Answer side
   output logic            pix_rd_valid,
   output logic      [7:0] pix_rdata
);
   // ==========================================================
   // One-byte store, answering reads three cycles late
   logic [7:0] mem_r  = 8'h00;
   logic [7:0] data_r = 8'h00;
   logic [1:0] pend_r = 2'h0;
   logic       vld_r  = 1'b0;
   always @(posedge mclk) begin
      pend_r <= {pend_r[0], pix_req & ~pix_we};
      vld_r  <= pend_r[1];
      // Outside the answer the lines toggle, so stale data matches only on every second cycle
      data_r <= pend_r[1] ? mem_r : ~data_r;
      if (pix_req && pix_we) begin
         mem_r <= pix_wdata;
      end
   end
   assign pix_rd_valid = vld_r;
   assign pix_rdata    = data_r;
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic mclk = 1'b0, rst_n = 1'b0, io_cs_n = 1'b1, e_clk = 1'b0;
   logic rd_wr = 1'b1, vblank_n = 1'b1, hblank_n = 1'b1;
   logic in_graphics = 1'b0, teletext_byte_done = 1'b0;
   logic teletext_active = 1'b0;
   logic [1:0] reg_sel = 2'h0;
   logic [7:0] ad_in = 8'h00;
   logic [3:0] shift_pixel = 4'h5;
   wire logic pix_rd_valid, ad_oe_n_r, pix_req_r, pix_we_r, pix_byte_r;
   wire logic high_bank_row_strobe_r, low_bank_row_strobe_r;
   wire logic line_sync_rate_select_r, interlace_select_r, vsync_oe_n_r;
   wire logic csync_enable_r, lookup_source_select_r;
   wire logic factory_test_select_r, transparency_bit_r;
   wire logic [7:0] pix_rdata, ad_out_r, pix_col_r, pix_row_r, pix_wdata_r;
   wire logic [7:0] scroll_r;
   wire logic [12:0] teletext_addr_r;
   wire logic [2:0] page_r;
   wire logic [3:0] red_level_r;
   int miscompares = 0;
   int checked = 0;
   logic [26:0] cap;
   logic [7:0] d;
   vpr_regs u_vpr_regs (.mclk, .rst_n, .io_cs_n, .e_clk, .rd_wr, .reg_sel,
      .ad_in, .ad_out_r, .ad_oe_n_r, .vblank_n, .hblank_n, .in_graphics,
      .shift_pixel, .pix_req_r, .pix_we_r, .pix_byte_r,
      .high_bank_row_strobe_r, .low_bank_row_strobe_r, .pix_col_r,
      .pix_row_r, .pix_wdata_r, .pix_rd_valid, .pix_rdata,
      .teletext_byte_done, .teletext_active, .teletext_addr_r, .mode_r(),
      .page_r, .scroll_r, .line_sync_rate_select_r, .interlace_select_r,
      .vsync_oe_n_r, .csync_enable_r, .lookup_source_select_r,
      .factory_test_select_r, .vsm_tick_test_r(), .red_level_r,
      .green_level_r(), .blue_level_r(), .transparency_bit_r);
   vpr_dram_model u_vpr_dram_model (.mclk, .pix_req(pix_req_r),
      .pix_we(pix_we_r), .pix_wdata(pix_wdata_r), .pix_rd_valid,
      .pix_rdata);
   // ==========================================================
   // Clock, capture of the last pixel request, watchdog
   initial forever #10 mclk = ~mclk;
   always @(posedge mclk) if (pix_req_r === 1'b1)
      cap <= {pix_byte_r, high_bank_row_strobe_r, low_bank_row_strobe_r,
              pix_col_r, pix_row_r, pix_wdata_r};
   initial begin
      #1ms;
      miscompares++;
      complete_run();
   end
   // ==========================================================
   // Shared tasks
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // Pins pass two sync stages, so E is held well past that
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      io_cs_n = 1'b0;
      rd_wr = 1'b0;
      reg_sel = a;
      ad_in = v;
      e_clk = 1'b1;
      cyc(4);
      e_clk = 1'b0;
      cyc(5);
      io_cs_n = 1'b1;
      cyc(1);
   endtask
   // Long E high lets a pixel read answer land before sampling
   task automatic rd(input logic [1:0] a, output logic [7:0] v);
      io_cs_n = 1'b0;
      rd_wr = 1'b1;
      reg_sel = a;
      e_clk = 1'b1;
      cyc(10);
      v = ad_out_r;
      chk("bus drive", 0, ad_oe_n_r);
      e_clk = 1'b0;
      cyc(5);
      io_cs_n = 1'b1;
      cyc(1);
   endtask
   function automatic logic [31:0] sw();
      return {line_sync_rate_select_r, interlace_select_r, vsync_oe_n_r,
              csync_enable_r, lookup_source_select_r, factory_test_select_r};
   endfunction
   // ==========================================================
   // Scenarios
   task automatic t_reset_switch();
      rd(2'h0, d);
      chk("status", 8'hc0, d);
      chk("switches", 6'h3b, sw());
      wr(2'h0, 8'h03);
      wr(2'h3, 8'h50);
      cyc(2);
      chk("switches", 6'h16, sw());
      wr(2'h3, 8'hf8);
      cyc(2);
      chk("switches", 6'h3b, sw());
      $display("test reset_switch done");
   endtask
   task automatic t_lookup();
      wr(2'h0, 8'h01);
      wr(2'h3, 8'h45);
      wr(2'h0, 8'h02);
      wr(2'h3, 8'hfa);
      cyc(2);
      chk("red level", 4'ha, red_level_r);
      rd(2'h3, d);
      chk("lookup read", 8'h0a, d);
      wr(2'h0, 8'h01);
      wr(2'h3, 8'h85);
      wr(2'h0, 8'h02);
      wr(2'h3, 8'h08);
      cyc(2);
      chk("transparency", 1, transparency_bit_r);
      chk("red kept", 4'ha, red_level_r);
      wr(2'h0, 8'h01);
      wr(2'h3, 8'h46);
      wr(2'h0, 8'h02);
      wr(2'h3, 8'h03);
      cyc(2);
      chk("border level", 4'h3, red_level_r);
      in_graphics = 1'b1;
      cyc(2);
      chk("pixel level", 4'ha, red_level_r);
      in_graphics = 1'b0;
      $display("test lookup done");
   endtask
   task automatic t_pixel();
      wr(2'h0, 8'h00);
      wr(2'h1, 8'h05);
      wr(2'h2, 8'h07);
      wr(2'h3, 8'h3c);
      chk("nibble request", 27'h2050700 | 8'h3c, cap);
      rd(2'h1, d);
      chk("x after nibble", 8'h05, d);
      wr(2'h0, 8'h08);
      wr(2'h1, 8'hfe);
      wr(2'h3, 8'ha5);
      chk("byte request", {1'b1, 2'h3, 8'hfe, 8'h07, 8'ha5},
          cap);
      rd(2'h1, d);
      chk("x wrapped", 8'h00, d);
      rd(2'h3, d);
      chk("byte read", 8'ha5, d);
      rd(2'h2, d);
      chk("y kept", 8'h07, d);
      $display("test pixel done");
   endtask
   task automatic t_misc();
      wr(2'h0, 8'h04);
      wr(2'h3, 8'hd1);
      chk("scroll", 8'hd1, scroll_r);
      wr(2'h0, 8'h06);
      wr(2'h3, 8'hfb);
      chk("page", 3'h3, page_r);
      rd(2'h0, d);
      chk("status", 8'hf3, d);
      wr(2'h0, 8'h07);
      wr(2'h3, 8'h00);
      wr(2'h1, 8'h11);
      chk("inert", {8'hd1, 3'h3}, {scroll_r, page_r});
      wr(2'h0, 8'h05);
      wr(2'h2, 8'h12);
      chk("ttx start", {8'h12, 5'h00}, teletext_addr_r);
      teletext_active = 1'b1;
      repeat (33) begin
         teletext_byte_done = 1'b1;
         cyc(1);
         teletext_byte_done = 1'b0;
         cyc(1);
      end
      cyc(2);
      chk("ttx count", {8'h13, 5'h01}, teletext_addr_r);
      chk("page held", 3'h3, page_r);
      teletext_active = 1'b0;
      rd(2'h2, d);
      chk("ttx pointer", 8'h13, d);
      $display("test misc done");
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      cyc(12);
      rst_n = 1'b1;
      cyc(8);
      t_reset_switch();
      t_lookup();
      t_pixel();
      t_misc();
      complete_run();
   end
endmodule
`default_nettype wire
